//--- core/cebs_bus_master.sv
`timescale 1ns/10ps
`default_nettype none

module cebs_bus_master
(
  input  wire logic                        xtal_in,
  input  wire logic                        rstn_in,
  input  wire cebs_pkg::cebs_req_t         req_in,
  input  wire logic                        req_valid_in,
  output logic                             req_ready_out,
  output logic [cebs_pkg::DATA_W-1:0]      rdata_out,
  output logic                             done_out,
  output logic                             mclk_out,
  output logic [cebs_pkg::ADDR_W-1:0]      word_address_lines_out,
  output logic                             addr_oe_n_out,
  output logic [cebs_pkg::DATA_W-1:0]      data_lines_out,
  output logic                             data_oe_n_out,
  input  wire logic [cebs_pkg::DATA_W-1:0] data_lines_in,
  output logic                             address_valid_strobe_n_out,
  output logic                             low_lane_strobe_n_out,
  output logic                             high_lane_strobe_n_out,
  output logic                             read_not_write_out,
  output logic                             ctrl_oe_n_out,
  input  wire logic                        transfer_ack_n_in,
  input  wire logic                        stop_request_n_in
);

  ////////////////////////////////////////////////////////////////////////
  logic                        mclk_r;
  logic                        ph_r;
  cebs_pkg::cebs_state_t       st_r;
  cebs_pkg::cebs_req_t         cur_r;
  logic                        ack_s1_r;
  logic                        ack_s2_r;
  logic                        halt_s1_r;
  logic                        halt_s2_r;
  logic [cebs_pkg::DATA_W-1:0] din_s1_r;
  logic [cebs_pkg::DATA_W-1:0] din_s2_r;
  logic                        take_req;
  logic                        halt_idle;

  // RULE_06 Crystal divide two
  always_ff @(posedge xtal_in or negedge rstn_in)
  begin
    if (!rstn_in)
      mclk_r <= 1'b0;
    else
      mclk_r <= ~mclk_r;
  end

  assign mclk_out = mclk_r;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, on the crystal clock
  always_ff @(posedge xtal_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ack_s1_r  <= 1'b1;
      ack_s2_r  <= 1'b1;
      halt_s1_r <= 1'b1;
      halt_s2_r <= 1'b1;
      din_s1_r  <= cebs_pkg::DATA_RST;
      din_s2_r  <= cebs_pkg::DATA_RST;
    end
    else
    begin
      ack_s1_r  <= transfer_ack_n_in;
      ack_s2_r  <= ack_s1_r;
      halt_s1_r <= stop_request_n_in;
      halt_s2_r <= halt_s1_r;
      din_s1_r  <= data_lines_in;
      din_s2_r  <= din_s1_r;
    end
  end

  // Bus phase ticks on falling edge of the divided clock
  always_ff @(posedge xtal_in or negedge rstn_in)
  begin
    if (!rstn_in)
      ph_r <= 1'b0;
    else
      ph_r <= ~mclk_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // Take and halt decisions in idle
  assign take_req  = (st_r == cebs_pkg::ST_IDLE) && halt_s2_r
                     && req_valid_in;
  assign halt_idle = (st_r == cebs_pkg::ST_IDLE) && !halt_s2_r;

  ////////////////////////////////////////////////////////////////////////
  // Bus cycle sequencer
  always_ff @(posedge xtal_in or negedge rstn_in)
  begin
    if (!rstn_in)
      st_r <= cebs_pkg::ST_IDLE;
    else if (ph_r)
    begin
      unique case (st_r)
        cebs_pkg::ST_IDLE:
        begin
          if (take_req)
            st_r <= cebs_pkg::ST_ADDR;
        end
        cebs_pkg::ST_ADDR:
          st_r <= cebs_pkg::ST_STRB;
        cebs_pkg::ST_STRB:
          st_r <= cebs_pkg::ST_WAIT;
        cebs_pkg::ST_WAIT:
        begin
          // RULE_09 Wait for acknowledge
          if (!ack_s2_r)
            st_r <= cebs_pkg::ST_END;
        end
        cebs_pkg::ST_END:
          st_r <= cebs_pkg::ST_IDLE;
        default:
          st_r <= cebs_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request capture and ready pulse
  always_ff @(posedge xtal_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cur_r         <= '0;
      req_ready_out <= 1'b0;
    end
    else
    begin
      req_ready_out <= ph_r && take_req;
      if (ph_r && take_req)
        cur_r <= req_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address and direction pins
  always_ff @(posedge xtal_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      word_address_lines_out <= cebs_pkg::ADDR_RST;
      addr_oe_n_out          <= 1'b1;
      ctrl_oe_n_out          <= 1'b1;
      read_not_write_out     <= 1'b1;
    end
    else if (ph_r)
    begin
      // RULE_10 Halt floats lines
      if (halt_idle)
      begin
        addr_oe_n_out      <= 1'b1;
        ctrl_oe_n_out      <= 1'b1;
        read_not_write_out <= 1'b1;
      end
      else if (take_req)
      begin
        // RULE_01 Drive word address
        word_address_lines_out <= req_in.addr;
        addr_oe_n_out          <= 1'b0;
        ctrl_oe_n_out          <= 1'b0;
        // RULE_08 Direction per cycle
        read_not_write_out     <= req_in.rd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write data pins
  always_ff @(posedge xtal_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      data_lines_out <= cebs_pkg::DATA_RST;
      data_oe_n_out  <= 1'b1;
    end
    else if (ph_r)
    begin
      // RULE_02 Drive data on write
      if (st_r == cebs_pkg::ST_ADDR)
      begin
        data_lines_out <= cur_r.wdata;
        data_oe_n_out  <= cur_r.rd;
      end
      else if ((st_r == cebs_pkg::ST_END) || halt_idle)
        data_oe_n_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address and lane strobes
  always_ff @(posedge xtal_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      address_valid_strobe_n_out <= 1'b1;
      low_lane_strobe_n_out      <= 1'b1;
      high_lane_strobe_n_out     <= 1'b1;
    end
    else if (ph_r)
    begin
      // RULE_03 Strobe after address
      if (st_r == cebs_pkg::ST_ADDR)
        address_valid_strobe_n_out <= 1'b0;
      // RULE_04 Low lane strobe
      if (st_r == cebs_pkg::ST_STRB)
        low_lane_strobe_n_out <= ~cur_r.lane_lo;
      // RULE_07 High lane strobe
      if (st_r == cebs_pkg::ST_STRB)
        high_lane_strobe_n_out <= ~cur_r.lane_hi;
      // RULE_11 Release strobes together
      if (st_r == cebs_pkg::ST_END)
      begin
        address_valid_strobe_n_out <= 1'b1;
        low_lane_strobe_n_out      <= 1'b1;
        high_lane_strobe_n_out     <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // End pulse and read data
  always_ff @(posedge xtal_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      done_out  <= 1'b0;
      rdata_out <= cebs_pkg::DATA_RST;
    end
    else
    begin
      done_out <= ph_r && (st_r == cebs_pkg::ST_END);
      // RULE_05 Capture read lanes once settled
      if (ph_r && (st_r == cebs_pkg::ST_END) && cur_r.rd)
        rdata_out <= din_s2_r;
    end
  end

endmodule : cebs_bus_master

`default_nettype wire

//--- core/cebs_pkg.sv
// Notes on behaviour
// RULE_01 - Drive 23-line word address, can float
// RULE_02 - 16-bit data bus, driven only on writes
// RULE_03 - Address strobe low only with valid address
// RULE_04 - Low lane strobe marks valid write byte
// RULE_05 - Addressed party returns low byte on reads; code reads all 16 lines, cebs_mem returns each strobed byte
// RULE_06 - Bus clock is crystal divided by two
// RULE_07 - High lane strobe mirrors low lane, upper byte
// RULE_08 - Direction high for read, low for write
// RULE_09 - Wait states until transfer acknowledge arrives
// RULE_10 - Halt stops after cycle, outputs float
// RULE_11 - All strobes release together at cycle end
package cebs_pkg;

  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_RST = 23'h000000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              rd;
    logic              lane_lo;
    logic              lane_hi;
  } cebs_req_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_STRB,
    ST_WAIT,
    ST_END
  } cebs_state_t;

endpackage : cebs_pkg

//--- sim/cebs_chk.sv
`timescale 1ns/10ps
`default_nettype none
module cebs_chk (
  input wire logic xtal_in, rstn_in, mclk_out, transfer_ack_n_in,
  input wire logic address_valid_strobe_n_out, read_not_write_out,
  input wire logic low_lane_strobe_n_out, high_lane_strobe_n_out,
  input wire logic addr_oe_n_out, ctrl_oe_n_out, data_oe_n_out,
  input wire logic [cebs_pkg::ADDR_W-1:0] word_address_lines_out
);
  default clocking @(posedge xtal_in); endclocking
  default disable iff (!rstn_in);
  wire as_n = address_valid_strobe_n_out;
  wire lo_n = low_lane_strobe_n_out;
  wire hi_n = high_lane_strobe_n_out;
  wire rnw = read_not_write_out;
  property p_as; !as_n |-> !addr_oe_n_out && !ctrl_oe_n_out; endproperty
  a_as: assert property (p_as) else $error("strobe, no address");
  property p_dir; !data_oe_n_out |-> !rnw; endproperty
  a_dir: assert property (p_dir) else $error("data on read");
  property p_lo; !lo_n && !rnw |-> !data_oe_n_out; endproperty
  a_lo: assert property (p_lo) else $error("lane, no data");
  property p_hi; !hi_n |-> !as_n; endproperty
  a_hi: assert property (p_hi) else $error("lane outside cycle");
  property p_end; $rose(as_n) |-> lo_n && hi_n; endproperty
  a_end: assert property (p_end) else $error("strobes apart");
  property p_wait; (!as_n && transfer_ack_n_in)[*3] |=> !as_n; endproperty
  a_wait: assert property (p_wait) else $error("end, no ack");
  property p_clk; 1 |=> mclk_out != $past(mclk_out); endproperty
  a_clk: assert property (p_clk) else $error("clock not halved");
  property p_adr; !as_n ##1 !as_n |-> $stable(word_address_lines_out)
    && $stable(rnw); endproperty
  a_adr: assert property (p_adr) else $error("addr moved");
endmodule : cebs_chk
bind cebs_bus_master cebs_chk u_chk (.*);
`default_nettype wire

//--- sim/cebs_mem.sv
`timescale 1ns/10ps
`default_nettype none
module cebs_mem (
  input wire logic clk_in, as_n_in, lo_n_in, hi_n_in, rnw_in, oe_n_in,
  input wire logic [3:0] a_in,
  input wire logic [15:0] d_in,
  input wire logic [7:0] wait_in,
  output var logic [15:0] q_out = 16'h0000,
  output var logic ack_n_out = 1'b1
);
  logic [15:0] mem [16];
  logic [7:0] cnt = 8'h00;
  always_ff @(posedge clk_in)
    if (as_n_in)
    begin
      q_out <= ~q_out;
      ack_n_out <= 1'b1;
      cnt <= 8'h00;
    end
    else
    begin
      cnt <= cnt + 8'h01;
      ack_n_out <= (cnt < wait_in) || (lo_n_in && hi_n_in);
      if (rnw_in) q_out <= {hi_n_in ? ~q_out[15:8] : mem[a_in][15:8],
                            lo_n_in ? ~q_out[7:0] : mem[a_in][7:0]};
      else if (!oe_n_in && !lo_n_in) mem[a_in][7:0] <= d_in[7:0];
      if (!rnw_in && !oe_n_in && !hi_n_in) mem[a_in][15:8] <= d_in[15:8];
    end
endmodule : cebs_mem
`default_nettype wire

//--- sim/test_cpu_external_bus_strobes.sv
`timescale 1ns/10ps
`default_nettype none
module test_cpu_external_bus_strobes;
  localparam logic [22:0] A = 23'h7FFFF5;
  logic clk = 1'b0, rstn = 1'b0, vld = 1'b0, stop = 1'b1;
  cebs_pkg::cebs_req_t req = '0;
  logic [7:0] wt = 8'h00;
  logic [15:0] q, rd, dq;
  logic [22:0] a;
  logic rdy, done, as_n, lo_n, hi_n, rnw, aoe, doe, coe, ack;
  int mismatches = 0, n_tests = 0;
  always #12.5 clk = ~clk;
  cebs_bus_master dut (.xtal_in(clk), .rstn_in(rstn), .req_in(req),
    .req_valid_in(vld), .req_ready_out(rdy), .rdata_out(rd),
    .done_out(done), .mclk_out(), .word_address_lines_out(a),
    .addr_oe_n_out(aoe), .data_lines_out(dq), .data_oe_n_out(doe),
    .data_lines_in(q), .address_valid_strobe_n_out(as_n),
    .low_lane_strobe_n_out(lo_n), .high_lane_strobe_n_out(hi_n),
    .read_not_write_out(rnw), .ctrl_oe_n_out(coe),
    .transfer_ack_n_in(ack), .stop_request_n_in(stop));
  cebs_mem mem (.clk_in(clk), .as_n_in(as_n), .lo_n_in(lo_n),
    .hi_n_in(hi_n), .rnw_in(rnw), .oe_n_in(doe), .a_in(a[3:0]),
    .d_in(dq), .wait_in(wt), .q_out(q), .ack_n_out(ack));
  task chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %0t %h %h", $time, s, e);
    end
  endtask : chk
  task report_and_stop;
    if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task start(input cebs_pkg::cebs_req_t r);
    req = r;
    vld = 1'b1;
    for (int i = 0; i < 99 && !rdy; i++) @(posedge clk) #2;
    vld = 1'b0;
  endtask : start
  task finish(output int n);
    for (n = 0; n < 300 && !done; n++) @(posedge clk) #2;
    chk(done, 1'b1);
  endtask : finish
  task t_word;
    int n;
    start({A, 16'h1234, 3'h3}); finish(n);
    chk({a, as_n, lo_n, hi_n, rnw, doe}, {A, 5'h1D});
    start({A, 16'h0000, 3'h7}); finish(n);
    chk(rd, 16'h1234);
    chk(rnw, 1'b1);
  endtask : t_word
  task t_lane;
    int n;
    start({A, 16'hABCD, 3'h2}); finish(n);
    start({A, 16'h0000, 3'h7}); finish(n);
    chk(rd, 16'h12CD);
    start({A, 16'h5600, 3'h1}); finish(n);
    start({A, 16'h0000, 3'h7}); finish(n);
    chk(rd, 16'h56CD);
  endtask : t_lane
  task t_slow;
    int n;
    wt = 8'h14;
    start({A, 16'h0000, 3'h7}); finish(n);
    chk(n >= 20, 1'b1);
  endtask : t_slow
  task t_halt;
    int n;
    wt = 8'h0A;
    start({A, 16'h0000, 3'h7});
    stop = 1'b0;
    finish(n);
    vld = 1'b1;
    @(posedge clk) #2;
    repeat (20)
    begin
      @(posedge clk) #2;
      chk({rdy, aoe, coe, doe}, 4'h7);
    end
    stop = 1'b1;
    start({A, 16'h0000, 3'h7}); finish(n);
    chk(rd, 16'h56CD);
  endtask : t_halt
  initial
  begin
    repeat (5) @(posedge clk);
    #2 rstn = 1'b1;
    t_word; t_lane; t_slow; t_halt;
    report_and_stop;
  end
  initial
  begin
    #100us;
    mismatches++;
    report_and_stop;
  end
endmodule : test_cpu_external_bus_strobes
`default_nettype wire
